// *** wotp_defs.svh ***
// timing, pulse-count and tap constants for the wiper fuse programmer
// Behaviour
// - move wiper to target before programming
// - ud, cs high; supply on; cs low
// - six cs pulses store the tap
// - seventh pulse also locks the wiper
// - program the part only once unless allow_reprogram_i is set
// - supply off first, then cs high
`ifndef WOTP_DEFS_SVH
`define WOTP_DEFS_SVH

`define WOTP_CLK_MHZ 100
`define WOTP_TCH_NS 1000
`define WOTP_TCL_NS 1000
`define WOTP_SETUP_NS 1000
`define WOTP_SETTLE_NS 100000
`define WOTP_TAP_W 6
`define WOTP_TAP_MAX 6'h3F
`define WOTP_TAP_MID 6'h1F
`define WOTP_PULSES_STORE 3'h6
`define WOTP_PULSES_LOCK 3'h7
`define WOTP_CNT_W 16

`endif

// *** wotp_pkg.sv ***
// types and helpers shared by the wiper fuse programmer
`include "wotp_defs.svh"

package wotp_pkg;

  typedef enum logic [1:0] {
    WOTP_OP_NONE = 2'h0,
    WOTP_OP_STEP = 2'h1,
    WOTP_OP_PROGRAM = 2'h2
  } wotp_op_t;

  typedef struct packed {
    wotp_op_t op;
    logic dir_up;
    logic [`WOTP_TAP_W-1:0] count;
    logic [`WOTP_TAP_W-1:0] tap;
    logic lock;
  } wotp_cmd_t;

  typedef struct packed {
    logic busy;
    logic programmed;
    logic locked;
    logic [`WOTP_TAP_W-1:0] fuse_image;
  } wotp_status_t;

  // least time in ns to whole clock cycles, rounded up, never below one
  function automatic logic [`WOTP_CNT_W-1:0] wotp_ns_to_cyc(input int ns);
    int c;
    c = (ns * `WOTP_CLK_MHZ + 999) / 1000;
    if (c < 1) begin
      c = 1;
    end
    return c[`WOTP_CNT_W-1:0];
  endfunction : wotp_ns_to_cyc

endpackage : wotp_pkg

// *** wotp_timer.sv ***
// down-counting wait timer with a registered expiry flag
`timescale 1ns/1ps
`include "wotp_defs.svh"

module wotp_timer #(
  parameter int CNT_W = `WOTP_CNT_W
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic start_i,
  input wire logic [CNT_W-1:0] count_i,
  output logic expired_o
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic exp_q;
  logic exp_d;

  always_comb begin
    if (start_i) begin
      cnt_d = count_i;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
    end else begin
      cnt_d = '0;
    end
    // a fresh start never reads as expired, so a stale flag cannot skip a wait
    exp_d = !start_i && (cnt_d == '0);
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      cnt_q <= '0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end

  assign expired_o = exp_q;

endmodule : wotp_timer

// *** wotp_programmer.sv ***
// host controller that steps a fuse-programmable potentiometer and burns its power-up tap
`timescale 1ns/1ps
`include "wotp_defs.svh"
module wotp_programmer
  import wotp_pkg::*;
#(
  parameter int TCH_NS = `WOTP_TCH_NS,
  parameter int TCL_NS = `WOTP_TCL_NS,
  parameter int SETUP_NS = `WOTP_SETUP_NS,
  parameter int SETTLE_NS = `WOTP_SETTLE_NS
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic cmd_valid_i,
  input wire wotp_cmd_t cmd_i,
  input wire logic allow_reprogram_i,
  output logic cmd_ready_o,
  output logic done_o,
  output logic refused_o,
  output wotp_status_t status_o,
  output logic cs_n_o,
  output logic ud_o,
  output logic fuse_program_supply_o
);
  typedef enum logic [11:0] {
    ST_IDLE    = 12'h001,
    ST_MV_DIR  = 12'h002,
    ST_MV_SEL  = 12'h004,
    ST_MV_UDL  = 12'h008,
    ST_MV_UDH  = 12'h010,
    ST_MV_DSEL = 12'h020,
    ST_P_PREP  = 12'h040,
    ST_P_SUP   = 12'h080,
    ST_P_LOW   = 12'h100,
    ST_P_HIGH  = 12'h200,
    ST_P_REL   = 12'h400,
    ST_P_END   = 12'h800
  } wotp_state_t;
  typedef enum logic [1:0] {PH_NONE = 2'h0, PH_DOWN = 2'h1, PH_UP = 2'h2} wotp_phase_t;
  localparam logic [`WOTP_CNT_W-1:0] TCH_CYC = wotp_ns_to_cyc(TCH_NS);
  localparam logic [`WOTP_CNT_W-1:0] TCL_CYC = wotp_ns_to_cyc(TCL_NS);
  localparam logic [`WOTP_CNT_W-1:0] SETUP_CYC = wotp_ns_to_cyc(SETUP_NS);
  localparam logic [`WOTP_CNT_W-1:0] SETTLE_CYC = wotp_ns_to_cyc(SETTLE_NS);
  wotp_state_t state_q, state_d;
  wotp_phase_t phase_q, phase_d;
  logic cs_n_q, cs_n_d;
  logic ud_q, ud_d;
  logic sup_q, sup_d;
  logic dir_q, dir_d;
  logic [`WOTP_TAP_W-1:0] left_q, left_d;
  logic [`WOTP_TAP_W-1:0] tap_q, tap_d;
  logic lock_q, lock_d;
  logic [2:0] pulses_q, pulses_d;
  logic done_q, done_d;
  logic refused_q, refused_d;
  logic rdy_q, rdy_d, busy_q;
  logic programmed_q, programmed_d;
  logic locked_q, locked_d;
  logic [`WOTP_TAP_W-1:0] fuse_q, fuse_d;
  logic tmr_start, tmr_exp, accept;
  logic [`WOTP_CNT_W-1:0] tmr_count;
  logic [2:0] target_pulses;
  wotp_timer #(.CNT_W(`WOTP_CNT_W)) u_timer (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .start_i(tmr_start), .count_i(tmr_count), .expired_o(tmr_exp)
  );
  assign accept = cmd_valid_i && rdy_q && (state_q == ST_IDLE);
  assign target_pulses = lock_q ? `WOTP_PULSES_LOCK : `WOTP_PULSES_STORE;
  always_comb begin
    state_d = state_q;
    phase_d = phase_q;
    cs_n_d = cs_n_q;
    ud_d = ud_q;
    sup_d = sup_q;
    dir_d = dir_q;
    left_d = left_q;
    tap_d = tap_q;
    lock_d = lock_q;
    pulses_d = pulses_q;
    done_d = 1'b0;
    refused_d = 1'b0;
    programmed_d = programmed_q;
    locked_d = locked_q;
    fuse_d = fuse_q;
    tmr_start = 1'b0;
    tmr_count = '0;
    case (state_q)
      ST_IDLE: begin
        cs_n_d = 1'b1;
        ud_d = 1'b1;
        sup_d = 1'b0;
        if (accept) begin
          if (locked_q || cmd_i.op == WOTP_OP_NONE) begin
            // a locked part no longer listens, so nothing is driven at it
            refused_d = 1'b1;
          end else if (cmd_i.op == WOTP_OP_STEP) begin
            if (cmd_i.count == '0) begin
              done_d = 1'b1;
            end else begin
              dir_d = cmd_i.dir_up;
              left_d = cmd_i.count;
              phase_d = PH_NONE;
              state_d = ST_MV_DIR;
              tmr_start = 1'b1;
              tmr_count = SETUP_CYC;
            end
          end else if (programmed_q && !allow_reprogram_i) begin
            refused_d = 1'b1;
          end else begin
            // a full down run parks the wiper at tap 0 whatever its start
            tap_d = cmd_i.tap;
            lock_d = cmd_i.lock;
            dir_d = 1'b0;
            left_d = `WOTP_TAP_MAX;
            phase_d = PH_DOWN;
            state_d = ST_MV_DIR;
            tmr_start = 1'b1;
            tmr_count = SETUP_CYC;
          end
        end
      end
      ST_MV_DIR: begin
        ud_d = dir_q;
        cs_n_d = 1'b1;
        if (tmr_exp) begin
          cs_n_d = 1'b0;
          state_d = ST_MV_SEL;
          tmr_start = 1'b1;
          tmr_count = TCL_CYC;
        end
      end
      ST_MV_SEL: begin
        if (tmr_exp) begin
          ud_d = 1'b0;
          state_d = ST_MV_UDL;
          tmr_start = 1'b1;
          tmr_count = TCL_CYC;
        end
      end
      ST_MV_UDL: begin
        if (tmr_exp) begin
          ud_d = 1'b1;
          left_d = left_q - 6'h01;
          state_d = ST_MV_UDH;
          tmr_start = 1'b1;
          tmr_count = TCH_CYC;
        end
      end
      ST_MV_UDH: begin
        if (tmr_exp) begin
          tmr_start = 1'b1;
          // ud is high here, so releasing cs adds no extra step
          if (left_q == '0) begin
            cs_n_d = 1'b1;
            state_d = ST_MV_DSEL;
            tmr_count = TCH_CYC;
          end else begin
            ud_d = 1'b0;
            state_d = ST_MV_UDL;
            tmr_count = TCL_CYC;
          end
        end
      end
      ST_MV_DSEL: begin
        if (tmr_exp) begin
          tmr_start = 1'b1;
          tmr_count = SETUP_CYC;
          if (phase_q == PH_DOWN && tap_q != '0) begin
            dir_d = 1'b1;
            left_d = tap_q;
            phase_d = PH_UP;
            state_d = ST_MV_DIR;
          end else if (phase_q == PH_NONE) begin
            done_d = 1'b1;
            state_d = ST_IDLE;
          end else begin
            phase_d = PH_NONE;
            state_d = ST_P_PREP;
          end
        end
      end
      ST_P_PREP: begin
        ud_d = 1'b1;
        cs_n_d = 1'b1;
        if (tmr_exp) begin
          sup_d = 1'b1;
          state_d = ST_P_SUP;
          tmr_start = 1'b1;
          tmr_count = SETTLE_CYC;
        end
      end
      ST_P_SUP: begin
        if (tmr_exp) begin
          cs_n_d = 1'b0;
          pulses_d = 3'h0;
          state_d = ST_P_LOW;
          tmr_start = 1'b1;
          tmr_count = TCL_CYC;
        end
      end
      ST_P_LOW: begin
        if (tmr_exp) begin
          tmr_start = 1'b1;
          if (pulses_q == target_pulses) begin
            sup_d = 1'b0;
            state_d = ST_P_REL;
            tmr_count = SETTLE_CYC;
          end else begin
            cs_n_d = 1'b1;
            state_d = ST_P_HIGH;
            tmr_count = TCH_CYC;
          end
        end
      end
      ST_P_HIGH: begin
        if (tmr_exp) begin
          cs_n_d = 1'b0;
          pulses_d = pulses_q + 3'h1;
          state_d = ST_P_LOW;
          tmr_start = 1'b1;
          tmr_count = TCL_CYC;
        end
      end
      ST_P_REL: begin
        if (tmr_exp) begin
          cs_n_d = 1'b1;
          state_d = ST_P_END;
          tmr_start = 1'b1;
          tmr_count = TCH_CYC;
        end
      end
      ST_P_END: begin
        if (tmr_exp) begin
          programmed_d = 1'b1;
          locked_d = locked_q | lock_q;
          // fuses only ever blow, so the image tracks the OR of every burn
          fuse_d = fuse_q | tap_q;
          done_d = 1'b1;
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
        cs_n_d = 1'b1;
        ud_d = 1'b1;
        sup_d = 1'b0;
      end
    endcase
    rdy_d = (state_d == ST_IDLE);
  end
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      state_q <= ST_IDLE;
      phase_q <= PH_NONE;
      cs_n_q <= 1'b1;
      ud_q <= 1'b1;
      sup_q <= 1'b0;
      dir_q <= 1'b1;
      left_q <= '0;
      tap_q <= `WOTP_TAP_MID;
      lock_q <= 1'b0;
      pulses_q <= 3'h0;
      done_q <= 1'b0;
      refused_q <= 1'b0;
      rdy_q <= 1'b0;
      busy_q <= 1'b1;
      programmed_q <= 1'b0;
      locked_q <= 1'b0;
      fuse_q <= '0;
    end else begin
      state_q <= state_d;
      phase_q <= phase_d;
      cs_n_q <= cs_n_d;
      ud_q <= ud_d;
      sup_q <= sup_d;
      dir_q <= dir_d;
      left_q <= left_d;
      tap_q <= tap_d;
      lock_q <= lock_d;
      pulses_q <= pulses_d;
      done_q <= done_d;
      refused_q <= refused_d;
      rdy_q <= rdy_d;
      busy_q <= !rdy_d;
      programmed_q <= programmed_d;
      locked_q <= locked_d;
      fuse_q <= fuse_d;
    end
  end
  assign cmd_ready_o = rdy_q;
  assign done_o = done_q;
  assign refused_o = refused_q;
  // busy has its own flop so that every status bit leaves straight from a register
  assign status_o = '{busy: busy_q, programmed: programmed_q, locked: locked_q, fuse_image: fuse_q};
  assign cs_n_o = cs_n_q;
  assign ud_o = ud_q;
  assign fuse_program_supply_o = sup_q;
endmodule : wotp_programmer

// *** wotp_programmer_assertions.sv ***
// concurrent checks on the pins and handshake of the wiper fuse programmer
`timescale 1ns/1ps
module wotp_programmer_assertions
  import wotp_pkg::*;
#(
  parameter int TCH_NS = 1000,
  parameter int TCL_NS = 1000
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_ready_o,
  input wire logic refused_o,
  input wire wotp_status_t status_o,
  input wire logic cs_n_o,
  input wire logic ud_o,
  input wire logic fuse_program_supply_o
);
  localparam int TCH_CYC = TCH_NS / 10;
  localparam int TCL_CYC = TCL_NS / 10;
  logic [15:0] hi_q;
  logic [15:0] lo_q;
  logic [3:0] pls_q;
  logic cs_prev_q;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  // the high and low counters saturate so a long idle stretch never wraps to a short one
  // select idles high through reset, so the high counter must start from a known value
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      cs_prev_q <= 1'h1;
      hi_q <= 16'h0000;
      lo_q <= 16'h0000;
      pls_q <= 4'h0;
    end else begin
      cs_prev_q <= cs_n_o;
      hi_q <= !cs_n_o ? 16'h0000 : hi_q + {15'h0000, ~&hi_q};
      lo_q <= cs_n_o ? 16'h0000 : lo_q + {15'h0000, ~&lo_q};
      pls_q <= !fuse_program_supply_o ? 4'h0 : pls_q + {3'h0, cs_n_o && !cs_prev_q};
    end
  end
  property p_supply_on; $rose(fuse_program_supply_o) |-> cs_n_o && ud_o; endproperty
  a_supply_on: assert property (p_supply_on) else $error("supply raised with pins low");
  property p_supply_off; $fell(fuse_program_supply_o) |-> !cs_n_o; endproperty
  a_supply_off: assert property (p_supply_off) else $error("select high before supply off");
  property p_pulses; $fell(fuse_program_supply_o) |-> pls_q inside {4'h6, 4'h7}; endproperty
  a_pulses: assert property (p_pulses) else $error("bad select pulse count");
  property p_cs_high; $fell(cs_n_o) |-> hi_q >= TCH_CYC; endproperty
  a_cs_high: assert property (p_cs_high) else $error("select high too short");
  property p_cs_low; $rose(cs_n_o) |-> lo_q >= TCL_CYC; endproperty
  a_cs_low: assert property (p_cs_low) else $error("select low too short");
  property p_locked_quiet; status_o.locked |-> cs_n_o && ud_o && !fuse_program_supply_o; endproperty
  a_locked_quiet: assert property (p_locked_quiet) else $error("pins move on locked part");
  property p_locked_refuse; cmd_valid_i && cmd_ready_o && status_o.locked |=> refused_o; endproperty
  a_locked_refuse: assert property (p_locked_refuse) else $error("locked part not refused");
  property p_fuse_or; (status_o.fuse_image & $past(status_o.fuse_image)) == $past(status_o.fuse_image); endproperty
  a_fuse_or: assert property (p_fuse_or) else $error("fuse bit cleared");
  property p_step_unpowered; $rose(ud_o) && !cs_n_o |-> !fuse_program_supply_o; endproperty
  a_step_unpowered: assert property (p_step_unpowered) else $error("step under supply");
  property p_idle; cmd_ready_o |-> cs_n_o && ud_o && !fuse_program_supply_o; endproperty
  a_idle: assert property (p_idle) else $error("pins not idle");
endmodule : wotp_programmer_assertions

// *** wotp_pot_model.sv ***
// behavioural model of the fuse-programmable potentiometer
`timescale 1ns/1ps
module wotp_pot_model (
  input wire logic por_n_i,
  input wire logic cs_n_i,
  input wire logic ud_i,
  input wire logic supply_i,
  output logic [5:0] wiper_o,
  output logic [5:0] fuse_o,
  output logic lock_o
);
  logic used_q;
  logic up_q;
  logic [3:0] pls_q;
  function automatic logic [5:0] stepped(input logic [5:0] w, input logic up);
    if (up && w != 6'h3F) begin
      return w + 6'h01;
    end else if (!up && w != 6'h00) begin
      return w - 6'h01;
    end
    return w;
  endfunction : stepped
  initial begin
    fuse_o = 6'h00;
    lock_o = 1'h0;
    used_q = 1'h0;
    up_q = 1'h1;
    pls_q = 4'h0;
    wiper_o = 6'h1F;
  end
  always @(posedge por_n_i) begin
    wiper_o = used_q ? fuse_o : 6'h1F;
  end
  always @(negedge cs_n_i) begin
    up_q = ud_i;
  end
  // the pulse count restarts only when the supply comes on, not at every select fall
  always @(posedge supply_i) begin
    pls_q = 4'h0;
  end
  always @(posedge ud_i) begin
    if (!cs_n_i && !lock_o && !supply_i) begin
      wiper_o = stepped(wiper_o, up_q);
    end
  end
  // releasing select with ud low slips one more tap, which a careful host never causes
  always @(posedge cs_n_i) begin
    if (supply_i) begin
      pls_q = pls_q + 4'h1;
    end else if (!ud_i && !lock_o) begin
      wiper_o = stepped(wiper_o, up_q);
    end
  end
  // fuses only burn when the supply goes away after a full pulse train
  always @(negedge supply_i) begin
    if (pls_q >= 4'h6) begin
      fuse_o = fuse_o | wiper_o;
      used_q = 1'h1;
    end
    if (pls_q >= 4'h7) begin
      lock_o = 1'h1;
    end
  end
endmodule : wotp_pot_model

// *** wotp_programmer_tb_top.sv ***
// self-checking testbench for the wiper fuse programmer
`timescale 1ns/1ps
module wotp_programmer_tb_top
  import wotp_pkg::*;
;
  logic clk, rst_n, valid, allow, por_n, ready, done, refused, cs_n, ud, supply, lock;
  logic [5:0] wiper;
  logic [5:0] fuse;
  wotp_cmd_t cmd;
  wotp_status_t status;
  int fail_count = 0;
  int comparisons = 0;
  wotp_programmer #(.TCH_NS(50), .TCL_NS(50), .SETUP_NS(50), .SETTLE_NS(100)) i_wotp_programmer (
    .core_clk_i(clk), .rstn_i(rst_n), .cmd_valid_i(valid), .cmd_i(cmd), .allow_reprogram_i(allow),
    .cmd_ready_o(ready), .done_o(done), .refused_o(refused), .status_o(status), .cs_n_o(cs_n),
    .ud_o(ud), .fuse_program_supply_o(supply));
  wotp_pot_model i_wotp_pot_model (.por_n_i(por_n), .cs_n_i(cs_n), .ud_i(ud), .supply_i(supply),
    .wiper_o(wiper), .fuse_o(fuse), .lock_o(lock));
  task automatic end_of_test();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic run(input wotp_op_t op, input logic dir, input logic [5:0] n, input logic lk,
                     input logic al, input logic er);
    int i;
    i = 0;
    @(negedge clk);
    while (ready !== 1'h1 && i < 50) begin
      @(negedge clk);
      i++;
    end
    cmd = '{op: op, dir_up: dir, count: n, tap: n, lock: lk};
    allow = al;
    valid = 1'h1;
    @(negedge clk);
    valid = 1'h0;
    while (done !== 1'h1 && refused !== 1'h1 && i < 30000) begin
      @(negedge clk);
      i++;
    end
    if (i >= 30000) begin
      fail_count++;
      $display("wrong value at %0t: timeout", $time);
      end_of_test();
    end
    chk({8'h00, refused}, {8'h00, er}, "refused");
  endtask : run
  // the model alone sees the power cycle; the host keeps its state
  task automatic power_cycle();
    por_n = 1'h0;
    #20;
    por_n = 1'h1;
    #20;
  endtask : power_cycle
  task automatic t_default();
    chk({3'h0, wiper}, 9'h01F, "power-up tap");
    chk(status, 9'h000, "status");
    chk({6'h00, cs_n, ud, supply}, 9'h006, "idle pins");
    $display("test default done");
  endtask : t_default
  task automatic t_step();
    run(WOTP_OP_STEP, 1'h1, 6'h03, 1'h0, 1'h0, 1'h0);
    chk({3'h0, wiper}, 9'h022, "step up");
    run(WOTP_OP_STEP, 1'h0, 6'h28, 1'h0, 1'h0, 1'h0);
    chk({3'h0, wiper}, 9'h000, "floor");
    run(WOTP_OP_STEP, 1'h1, 6'h3F, 1'h0, 1'h0, 1'h0);
    run(WOTP_OP_STEP, 1'h1, 6'h02, 1'h0, 1'h0, 1'h0);
    chk({3'h0, wiper}, 9'h03F, "ceiling");
    run(WOTP_OP_STEP, 1'h0, 6'h05, 1'h0, 1'h0, 1'h0);
    chk({3'h0, wiper}, 9'h03A, "step down");
    power_cycle();
    chk({3'h0, wiper}, 9'h01F, "unburnt power-up");
    run(WOTP_OP_NONE, 1'h0, 6'h00, 1'h0, 1'h0, 1'h1);
    $display("test step done");
  endtask : t_step
  task automatic t_prog6();
    run(WOTP_OP_PROGRAM, 1'h0, 6'h15, 1'h0, 1'h0, 1'h0);
    chk({2'h0, lock, fuse}, 9'h015, "fuse burn");
    chk(status, 9'h095, "status");
    power_cycle();
    chk({3'h0, wiper}, 9'h015, "stored tap");
    run(WOTP_OP_STEP, 1'h1, 6'h01, 1'h0, 1'h0, 1'h0);
    chk({3'h0, wiper}, 9'h016, "still adjustable");
    $display("test program six done");
  endtask : t_prog6
  task automatic t_reprog();
    run(WOTP_OP_PROGRAM, 1'h0, 6'h2A, 1'h1, 1'h0, 1'h1);
    chk({3'h0, fuse}, 9'h015, "fuses unchanged");
    run(WOTP_OP_PROGRAM, 1'h0, 6'h2A, 1'h1, 1'h1, 1'h0);
    chk({2'h0, lock, fuse}, 9'h07F, "or and lock");
    chk(status, 9'h0FF, "status");
    power_cycle();
    chk({3'h0, wiper}, 9'h03F, "merged tap");
    $display("test reprogram done");
  endtask : t_reprog
  task automatic t_locked();
    run(WOTP_OP_STEP, 1'h0, 6'h05, 1'h0, 1'h0, 1'h1);
    run(WOTP_OP_PROGRAM, 1'h0, 6'h01, 1'h0, 1'h1, 1'h1);
    chk({3'h0, wiper}, 9'h03F, "wiper fixed");
    $display("test locked done");
  endtask : t_locked
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst_n = 1'h0;
    valid = 1'h0;
    allow = 1'h0;
    por_n = 1'h1;
    cmd = '0;
    repeat (16) @(negedge clk);
    rst_n = 1'h1;
    @(negedge clk);
    t_default();
    t_step();
    t_prog6();
    t_reprog();
    t_locked();
    end_of_test();
  end
endmodule : wotp_programmer_tb_top
bind wotp_programmer wotp_programmer_assertions #(.TCH_NS(TCH_NS), .TCL_NS(TCL_NS)) i_chk (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
  .refused_o(refused_o), .status_o(status_o), .cs_n_o(cs_n_o), .ud_o(ud_o),
  .fuse_program_supply_o(fuse_program_supply_o));
